// file: rtl/prsc_ctrl_regs.v
// Purpose: input pll reference select and pump control registers
// Assumes: register strobes come from the serial port on mclk_i
// Notes:   reads answer one cycle after the read strobe
//
// How it works
// - Independent bit set: second R divider from its own registers.
// - Independent bit clear: second reference reuses first R divider.
// - Reference lost: tune output to midsupply if bit 6, else pump off.
// - Selection mode field in misc bits 4:2, resets to zero.
// - Bit 4 clear: bits 3:2 pick nonrevertive, revertive, or forced.
// - Bit 4 set: follow choice pin, low picks first reference.
// - Bit 4 set and choice pin high: second reference.
// - Zero resistor code bits 3:0 decode to value or external.
// - Output pll pump code is eight bits, about 3.5 uA per step.
`timescale 1ns/1ps
`include "prsc_consts.vh"

module prsc_ctrl_regs #(
  parameter RDIV_W = 16
) (
  input  wire              mclk_i,
  input  wire              rst_i,
  input  wire [11:0]       reg_addr_i,
  input  wire [7:0]        reg_wdata_i,
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  input  wire              ref_choice_pin_i,
  input  wire              first_ref_valid_i,
  input  wire              second_ref_valid_i,
  output reg  [7:0]        reg_rdata_o,
  output reg               reg_rvalid_o,
  output reg  [RDIV_W-1:0] first_ref_rdiv_o,
  output reg  [RDIV_W-1:0] second_ref_rdiv_o,
  output wire              use_second_ref_o,
  output wire              ref_lost_o,
  output reg               osc_tune_midsupply_o,
  output reg               input_pump_hiz_o,
  output reg  [9:0]        zero_res_kohm_o,
  output reg               zero_res_external_o,
  output reg  [7:0]        output_pump_code_o,
  output reg  [13:0]       output_pump_tenth_ua_o
);

  // stored registers
  reg  [7:0]  rdiv1_lo;
  reg  [7:0]  rdiv1_hi;
  reg  [7:0]  rdiv2_lo;
  reg  [7:0]  rdiv2_hi;
  reg  [7:0]  input_pll_misc_control;
  reg  [7:0]  input_pll_zero_resistor;
  reg  [7:0]  output_pll_pump_current;

  // choice pin synchroniser
  reg         pin_meta;
  reg         pin_sync;

  // decoded values
  reg  [7:0]  next_rdata;
  reg  [9:0]  next_kohm;
  reg         next_external;
  wire [15:0] rdiv1_full;
  wire [15:0] rdiv2_full;
  wire [15:0] next_rdiv2;
  wire        indep_div;
  wire        midsup_sel;
  wire        pin_mode;
  wire [1:0]  sel_mode;
  wire [7:0]  status_word;

  // stored value of a masked register after a write
  function [7:0] prsc_masked;
    input [7:0] wdata;
    input [7:0] wmask;
    begin
      prsc_masked = wdata & wmask;
    end
  endfunction

  // pump magnitude in tenths of a microamp
  function [13:0] prsc_pump_tenths;
    input [7:0] code;
    begin
      prsc_pump_tenths = {6'h00, code} * `PRSC_PUMP_STEP;
    end
  endfunction

  // field views of the misc control register
  assign indep_div  = input_pll_misc_control[`PRSC_MISC_INDEP];
  assign midsup_sel = input_pll_misc_control[`PRSC_MISC_MIDSUP];
  assign pin_mode   = input_pll_misc_control[`PRSC_MISC_PINMODE];
  assign sel_mode   = input_pll_misc_control[`PRSC_MISC_MODE_HI:
                                             `PRSC_MISC_MODE_LO];

  // divider words as seen by the dividers
  assign rdiv1_full = {rdiv1_hi, rdiv1_lo};
  assign rdiv2_full = {rdiv2_hi, rdiv2_lo};

  // shared divider keeps both references on one ratio, so the
  // loop only stays locked if both inputs run at one frequency
  assign next_rdiv2 = indep_div ? rdiv2_full
                                : rdiv1_full;

  // live state readable by software
  assign status_word = {3'h0, input_pump_hiz_o, osc_tune_midsupply_o,
                        pin_sync, ref_lost_o, use_second_ref_o};

  // pin comes from the board, two flops before any use
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= ref_choice_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // register writes; reserved bits are dropped so they read zero
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdiv1_lo                <= `PRSC_RDIV_RST;
      rdiv1_hi                <= `PRSC_RDIV_RST;
      rdiv2_lo                <= `PRSC_RDIV_RST;
      rdiv2_hi                <= `PRSC_RDIV_RST;
      input_pll_misc_control  <= `PRSC_MISC_RST;
      input_pll_zero_resistor <= `PRSC_ZRES_RST;
      output_pll_pump_current <= `PRSC_PUMP_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PRSC_OFS_RDIV1_LO: rdiv1_lo <= reg_wdata_i;
        `PRSC_OFS_RDIV1_HI: rdiv1_hi <= reg_wdata_i;
        `PRSC_OFS_RDIV2_LO: rdiv2_lo <= reg_wdata_i;
        `PRSC_OFS_RDIV2_HI: rdiv2_hi <= reg_wdata_i;
        `PRSC_OFS_MISC: begin
          input_pll_misc_control <=
            prsc_masked(reg_wdata_i, `PRSC_MISC_WMASK);
        end
        `PRSC_OFS_ZRES: begin
          input_pll_zero_resistor <=
            prsc_masked(reg_wdata_i, `PRSC_ZRES_WMASK);
        end
        `PRSC_OFS_PUMP: output_pll_pump_current <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr_i)
      `PRSC_OFS_RDIV1_LO: next_rdata = rdiv1_lo;
      `PRSC_OFS_RDIV1_HI: next_rdata = rdiv1_hi;
      `PRSC_OFS_RDIV2_LO: next_rdata = rdiv2_lo;
      `PRSC_OFS_RDIV2_HI: next_rdata = rdiv2_hi;
      `PRSC_OFS_MISC:     next_rdata = input_pll_misc_control;
      `PRSC_OFS_ZRES:     next_rdata = input_pll_zero_resistor;
      `PRSC_OFS_PUMP:     next_rdata = output_pll_pump_current;
      `PRSC_OFS_STATUS:   next_rdata = status_word;
      default:            next_rdata = 8'h00;
    endcase
  end

  // read answer, held until the next read
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end

  // zero resistor decode; codes above the external code also
  // select the external part rather than an undefined value
  always @* begin
    next_kohm     = `PRSC_RZ_10K;
    next_external = 1'b0;
    if (input_pll_zero_resistor[3]) begin
      next_kohm     = 10'h000;
      next_external = 1'b1;
    end else begin
      case (input_pll_zero_resistor[2:0])
        3'h0:    next_kohm = `PRSC_RZ_883K;
        3'h1:    next_kohm = `PRSC_RZ_677K;
        3'h2:    next_kohm = `PRSC_RZ_341K;
        3'h3:    next_kohm = `PRSC_RZ_135K;
        default: next_kohm = `PRSC_RZ_10K;
      endcase
    end
  end

  // reference choice engine
  prsc_ref_select u_sel (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .pin_mode_i     (pin_mode),
    .mode_i         (sel_mode),
    .pin_level_i    (pin_sync),
    .first_valid_i  (first_ref_valid_i),
    .second_valid_i (second_ref_valid_i),
    .use_second_o   (use_second_ref_o),
    .ref_lost_o     (ref_lost_o)
  );

  // analog control outputs, registered so nothing glitches
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      first_ref_rdiv_o       <= {RDIV_W{1'b0}};
      second_ref_rdiv_o      <= {RDIV_W{1'b0}};
      osc_tune_midsupply_o   <= 1'b0;
      input_pump_hiz_o       <= 1'b0;
      zero_res_kohm_o        <= `PRSC_RZ_883K;
      zero_res_external_o    <= 1'b0;
      output_pump_code_o     <= `PRSC_PUMP_RST;
      output_pump_tenth_ua_o <= 14'h0000;
    end else begin
      first_ref_rdiv_o  <= rdiv1_full[RDIV_W-1:0];
      second_ref_rdiv_o <= next_rdiv2[RDIV_W-1:0];
      // the two fail actions are exclusive: midsupply or tristate
      osc_tune_midsupply_o <= ref_lost_o & midsup_sel;
      input_pump_hiz_o     <= ref_lost_o & ~midsup_sel;
      zero_res_kohm_o        <= next_kohm;
      zero_res_external_o    <= next_external;
      output_pump_code_o     <= output_pll_pump_current;
      output_pump_tenth_ua_o <=
        prsc_pump_tenths(output_pll_pump_current);
    end
  end

endmodule

// file: rtl/prsc_consts.vh
// Purpose: constants of the reference select control registers
// Assumes: 12-bit register addresses, 8-bit register data
// Notes:   definitions only
`ifndef PRSC_CONSTS_VH
`define PRSC_CONSTS_VH

// register offsets
`define PRSC_OFS_RDIV1_LO 12'h010
`define PRSC_OFS_RDIV1_HI 12'h011
`define PRSC_OFS_RDIV2_LO 12'h012
`define PRSC_OFS_RDIV2_HI 12'h013
`define PRSC_OFS_MISC     12'h01c
`define PRSC_OFS_ZRES     12'h01d
`define PRSC_OFS_PUMP     12'h0f0
`define PRSC_OFS_STATUS   12'h1f0

// misc control fields
`define PRSC_MISC_INDEP   7
`define PRSC_MISC_MIDSUP  6
`define PRSC_MISC_PINMODE 4
`define PRSC_MISC_MODE_HI 3
`define PRSC_MISC_MODE_LO 2

// writable bits, reserved bits store nothing
`define PRSC_MISC_WMASK   8'hdc
`define PRSC_ZRES_WMASK   8'h0f

// reset values
`define PRSC_MISC_RST     8'h00
`define PRSC_ZRES_RST     8'h00
`define PRSC_PUMP_RST     8'h00
`define PRSC_RDIV_RST     8'h00

// reference selection modes, field bits 3:2
`define PRSC_MODE_NONREV  2'h0
`define PRSC_MODE_REVERT  2'h1
`define PRSC_MODE_FORCE1  2'h2
`define PRSC_MODE_FORCE2  2'h3

// zero resistor values in kilohm
`define PRSC_RZ_883K      10'h373
`define PRSC_RZ_677K      10'h2a5
`define PRSC_RZ_341K      10'h155
`define PRSC_RZ_135K      10'h087
`define PRSC_RZ_10K       10'h00a

// pump step in tenths of a microamp
`define PRSC_PUMP_STEP    14'h0023

`endif

// file: rtl/prsc_ref_select.v
// Purpose: chooses the reference the input pll locks to
// Assumes: valid flags and the pin level already on mclk_i
// Notes:   state and lost flag are registered
`timescale 1ns/1ps
`include "prsc_consts.vh"

module prsc_ref_select (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       pin_mode_i,
  input  wire [1:0] mode_i,
  input  wire       pin_level_i,
  input  wire       first_valid_i,
  input  wire       second_valid_i,
  output wire       use_second_o,
  output reg        ref_lost_o
);

  localparam ON_FIRST  = 2'b01;
  localparam ON_SECOND = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        next_lost;

  assign use_second_o = state[1];

  // pick the next reference from the mode and validity
  always @* begin
    next_state = state;
    if (pin_mode_i) begin
      // pin low chooses the first reference
      next_state = pin_level_i ? ON_SECOND : ON_FIRST;
    end else begin
      case (mode_i)
        `PRSC_MODE_FORCE1: next_state = ON_FIRST;
        `PRSC_MODE_FORCE2: next_state = ON_SECOND;
        `PRSC_MODE_REVERT: begin
          // back to the first as soon as it is good again
          if (first_valid_i)
            next_state = ON_FIRST;
          else if (second_valid_i)
            next_state = ON_SECOND;
        end
        `PRSC_MODE_NONREV: begin
          // switch only on failure, never back on recovery
          case (state)
            ON_FIRST: begin
              if (!first_valid_i && second_valid_i)
                next_state = ON_SECOND;
            end
            ON_SECOND: begin
              if (!second_valid_i && first_valid_i)
                next_state = ON_FIRST;
            end
            default: next_state = ON_FIRST;
          endcase
        end
        default: next_state = ON_FIRST;
      endcase
    end
    next_lost = next_state[1] ? !second_valid_i : !first_valid_i;
  end

  // state and loss flag
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state      <= ON_FIRST;
      ref_lost_o <= 1'b0;
    end else begin
      state      <= next_state;
      ref_lost_o <= next_lost;
    end
  end

endmodule

// file: dv/prsc_ctrl_regs_properties.sv
// Purpose: port checker for the reference select control registers
// Assumes: one clock mclk_i, asynchronous active high rst_i
// Notes:   attached to the register block by the bind below
`timescale 1ns/1ps
module prsc_checker #(
  parameter RDIV_W = 16
) (
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic [11:0]       reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              reg_rvalid_o,
  input wire logic [RDIV_W-1:0] first_ref_rdiv_o,
  input wire logic [RDIV_W-1:0] second_ref_rdiv_o,
  input wire logic              ref_lost_o,
  input wire logic              osc_tune_midsupply_o,
  input wire logic              input_pump_hiz_o,
  input wire logic [9:0]        zero_res_kohm_o,
  input wire logic              zero_res_external_o,
  input wire logic [7:0]        output_pump_code_o,
  input wire logic [13:0]       output_pump_tenth_ua_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // register port: one answer per read strobe, data only moves with it
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered");
  a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without read");
  a_rdata_held: assert property (
    $changed(reg_rdata_o) |-> reg_rvalid_o)
    else $error("read data moved without valid");
  // shared divider once the independent bit is written clear
  a_shared_divider: assert property (
    (reg_wr_i && reg_addr_i == 12'h01c
    && !reg_wdata_i[7]) ##1 !reg_wr_i |=>
    second_ref_rdiv_o == first_ref_rdiv_o)
    else $error("second divider not shared");
  // exactly one fail action follows a lost reference, none without it
  a_fail_action: assert property (ref_lost_o |=>
    osc_tune_midsupply_o != input_pump_hiz_o)
    else $error("fail action missing");
  a_fail_cause: assert property (
    (osc_tune_midsupply_o || input_pump_hiz_o) |-> $past(ref_lost_o))
    else $error("fail action without lost reference");
  a_zres_external: assert property (zero_res_external_o ==
    (zero_res_kohm_o == 10'h000))
    else $error("external flag and value disagree");
  a_pump_scale: assert property (output_pump_tenth_ua_o ==
    {6'h00, output_pump_code_o} * 14'h0023)
    else $error("pump current not code times step");

  c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
  c_lost: cover property (ref_lost_o ##1 osc_tune_midsupply_o);
  c_external: cover property (zero_res_external_o);
endmodule

bind prsc_ctrl_regs prsc_checker #(.RDIV_W(RDIV_W)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .first_ref_rdiv_o(first_ref_rdiv_o), .second_ref_rdiv_o(second_ref_rdiv_o),
  .ref_lost_o(ref_lost_o), .osc_tune_midsupply_o(osc_tune_midsupply_o),
  .input_pump_hiz_o(input_pump_hiz_o), .zero_res_kohm_o(zero_res_kohm_o),
  .zero_res_external_o(zero_res_external_o),
  .output_pump_code_o(output_pump_code_o),
  .output_pump_tenth_ua_o(output_pump_tenth_ua_o));

// file: dv/tb_pll_reference_select_controls.sv
// Purpose: self-checking bench for the reference select registers
// Assumes: inputs driven on the falling edge, 50 ns clock
// Notes:   each scenario is a task that judges its own results
`timescale 1ns/1ps
module tb_pll_reference_select_controls;
  reg         mclk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [11:0] addr = 12'h000;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         pin = 1'b0;
  reg         v1 = 1'b1;
  reg         v2 = 1'b1;
  reg  [7:0]  rv;
  wire [7:0]  rdata;
  wire        rvalid;
  wire [15:0] div1;
  wire [15:0] div2;
  wire        use2;
  wire        lost;
  wire        mid;
  wire        hiz;
  wire [9:0]  kohm;
  wire        ext;
  wire [7:0]  pcode;
  wire [13:0] pua;
  integer     err_count = 0;
  integer     comparisons = 0;

  always #25 mclk_i = ~mclk_i;

  prsc_ctrl_regs #(.RDIV_W(16)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .ref_choice_pin_i(pin), .first_ref_valid_i(v1),
    .second_ref_valid_i(v2), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .first_ref_rdiv_o(div1), .second_ref_rdiv_o(div2),
    .use_second_ref_o(use2), .ref_lost_o(lost),
    .osc_tune_midsupply_o(mid), .input_pump_hiz_o(hiz),
    .zero_res_kohm_o(kohm), .zero_res_external_o(ext),
    .output_pump_code_o(pcode), .output_pump_tenth_ua_o(pua));

  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // each access starts on a fresh edge so a strobe never toggles twice
  task wr_reg(input [11:0] a, input [7:0] d);
    begin
      @(negedge mclk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge mclk_i);
      wr = 1'b0;
    end
  endtask

  task rd_reg(input [11:0] a);
    integer n;
    begin
      @(negedge mclk_i);
      addr = a;
      rd = 1'b1;
      @(negedge mclk_i);
      rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
        @(negedge mclk_i);
        n = n + 1;
      end
      if (n == 4) begin
        err_count = err_count + 1;
        print_verdict;
      end else begin
        rv = rdata;
      end
    end
  endtask

  task chk_reg(input string name, input [11:0] a, input [7:0] e);
    begin
      rd_reg(a);
      chk(name, {8'h00, rv}, {8'h00, e});
    end
  endtask

  task settle;
    repeat (4) @(negedge mclk_i);
  endtask

  task t_reset_and_reserved;
    begin
      chk_reg("misc", 12'h01c, 8'h00);
      chk_reg("zres", 12'h01d, 8'h00);
      chk("kohm", {6'h00, kohm}, 16'h0373);
      // software keeps reserved bits zero, so only writable bits are set
      wr_reg(12'h01c, 8'hdc);
      chk_reg("misc", 12'h01c, 8'hdc);
      wr_reg(12'h01d, 8'h0f);
      chk_reg("zres", 12'h01d, 8'h0f);
      wr_reg(12'h0aa, 8'h55);
      chk_reg("unmapped", 12'h0aa, 8'h00);
      wr_reg(12'h01c, 8'h00);
      $display("test reset and reserved done");
    end
  endtask

  task t_divider;
    begin
      wr_reg(12'h010, 8'h34);
      wr_reg(12'h011, 8'h12);
      wr_reg(12'h012, 8'h78);
      wr_reg(12'h013, 8'h56);
      wr_reg(12'h01c, 8'h80);
      settle;
      chk("second", div2, 16'h5678);
      chk("first", div1, 16'h1234);
      wr_reg(12'h01c, 8'h00);
      settle;
      chk("second", div2, 16'h1234);
      $display("test divider done");
    end
  endtask

  // codes 8 and up count as external in this design
  task t_zres_pump;
    integer i;
    reg [9:0] e;
    reg [7:0] c;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        wr_reg(12'h01d, i[7:0]);
        settle;
        e = (i == 0) ? 10'h373 : (i == 1) ? 10'h2a5 : (i == 2) ? 10'h155 :
            (i == 3) ? 10'h087 : (i < 8) ? 10'h00a : 10'h000;
        chk("kohm", {6'h00, kohm}, {6'h00, e});
        chk("ext", {15'h0000, ext}, {15'h0000, i > 7});
      end
      for (i = 0; i < 3; i = i + 1) begin
        c = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'hff;
        wr_reg(12'h0f0, c);
        settle;
        chk("pump", {2'h0, pua}, {8'h00, c} * 16'h0023);
        chk("pcode", {8'h00, pcode}, {8'h00, c});
      end
      $display("test zero resistor and pump done");
    end
  endtask

  task t_modes;
    begin
      pin = 1'b1;
      wr_reg(12'h01c, 8'h08);
      settle;
      chk("use2", {15'h0000, use2}, 16'h0000);
      wr_reg(12'h01c, 8'h0c);
      settle;
      chk("use2", {15'h0000, use2}, 16'h0001);
      wr_reg(12'h01c, 8'h10);
      settle;
      chk("use2", {15'h0000, use2}, 16'h0001);
      pin = 1'b0;
      settle;
      chk("use2", {15'h0000, use2}, 16'h0000);
      $display("test modes done");
    end
  endtask

  task t_failover;
    begin
      wr_reg(12'h01c, 8'h04);
      v1 = 1'b0;
      settle;
      chk("use2", {15'h0000, use2}, 16'h0001);
      chk("lost", {15'h0000, lost}, 16'h0000);
      v1 = 1'b1;
      settle;
      chk("use2", {15'h0000, use2}, 16'h0000);
      wr_reg(12'h01c, 8'h40);
      v1 = 1'b0;
      settle;
      v1 = 1'b1;
      settle;
      chk("use2", {15'h0000, use2}, 16'h0001);
      v1 = 1'b0;
      v2 = 1'b0;
      settle;
      chk("lost", {14'h0000, mid, hiz}, 16'h0002);
      chk("lostflag", {15'h0000, lost}, 16'h0001);
      wr_reg(12'h01c, 8'h00);
      settle;
      chk("hiz", {14'h0000, mid, hiz}, 16'h0001);
      // status: pump off, pin low, reference lost, on second
      chk_reg("status", 12'h1f0, 8'h13);
      $display("test failover done");
    end
  endtask

  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    t_reset_and_reserved;
    t_divider;
    t_zres_pump;
    t_modes;
    t_failover;
    print_verdict;
  end
endmodule
